// *** logic/ptd_pkg.sv ***
// Shared constants for the PIO teach and direct-move command logic
package ptd_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_PERIOD_NS = 20; // 50 MHz scan clock
	localparam int MS_NS = 1000000; // One millisecond in ns
	localparam int CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS; // Cycles per ms
	localparam int CAP_MIN_MS = 20; // Least capture request hold
	localparam int CMD_MIN_MS = 6; // Least direct move command hold
	localparam int CLR_MIN_MS = 6; // Least clear pulse
	localparam int MS_CNT_W = 6; // Width of the per-input ms counter
	localparam int TICK_W = 16; // Width of the ms tick divider
	// ==========================================================
	// Widths
	localparam int N_DIRECT = 7; // Direct move inputs 0 to 6
	localparam int IDX_W = 3; // Position number width
	localparam int POS_W = 32; // Actuator position width
	localparam int PAR_W = 16; // Parameter value width
	// ==========================================================
	// Synchronised input vector layout
	localparam int IN_MODE = 0; // Mode select
	localparam int IN_JFWD = 1; // Jog forward
	localparam int IN_JREV = 2; // Jog reverse
	localparam int IN_INCH = 3; // Inch/jog select
	localparam int IN_HOLD = 4; // Hold, active low
	localparam int IN_POS0 = 5; // Command position number, 3 bits
	localparam int IN_CAP = 8; // Capture request
	localparam int IN_CLR = 9; // Clear remaining travel
	localparam int IN_DM0 = 10; // Direct move commands, 7 bits
	localparam int N_IN = 17; // Total inputs filtered
	// ==========================================================
	// Register map of the PLC end (APB, byte addresses)
	localparam logic [11:0] ADDR_CTRL = 12'h000; // Control bits
	localparam logic [11:0] ADDR_MOVE = 12'h004; // Direct move bits
	localparam logic [11:0] ADDR_STAT = 12'h008; // Status, read only
	localparam logic [31:0] CTRL_RST = 32'h0000_0010; // Hold released
	localparam int CB_POS = 5; // Command position field lsb in CTRL
	// Status bit positions
	localparam int SB_DONE = 0;
	localparam int SB_TEACH = 1;
	localparam int SB_MOVE = 2;

	// Minimum hold in ms for each filtered input; 0 means plain sync
	function automatic int thr_ms(input int i);
		if (i == IN_CAP) begin
			return CAP_MIN_MS;
		end else if (i == IN_CLR) begin
			return CLR_MIN_MS;
		end else if (i >= IN_DM0) begin
			return CMD_MIN_MS;
		end
		return 0;
	endfunction

	// Direct-move controller states
	typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_HOLD, ST_STOP} ptd_state_t;
endpackage

// *** logic/ptd_if.sv ***
// Parallel I/O bundle between the PLC end and the positioning device end
`timescale 1ns/100ps
interface ptd_if;
	import ptd_pkg::*;
	logic mode_select; // Teach mode request
	logic jog_fwd; // Jog forward
	logic jog_rev; // Jog reverse
	logic inch_jog_select; // High inching, low jogging
	logic capture_position_request; // Capture current position
	logic [IDX_W-1:0] cmd_position; // Entry for capture
	logic [N_DIRECT-1:0] direct_move_cmd_n; // Direct move commands, high active
	logic hold_n; // Pause, active low
	logic clear_travel_input; // Cancel remaining travel
	logic capture_done; // Capture finished
	logic teach_mode_active; // Teach mode in effect
	logic move_active; // Direct move in progress

	modport plc (
		output mode_select, jog_fwd, jog_rev, inch_jog_select, capture_position_request,
		output cmd_position, direct_move_cmd_n, hold_n, clear_travel_input,
		input capture_done, teach_mode_active, move_active
	);
	modport dev (
		input mode_select, jog_fwd, jog_rev, inch_jog_select, capture_position_request,
		input cmd_position, direct_move_cmd_n, hold_n, clear_travel_input,
		output capture_done, teach_mode_active, move_active
	);
endinterface

// *** logic/ptd_qual.sv ***
// Input synchroniser with a millisecond minimum-width qualifier
`timescale 1ns/100ps
module ptd_qual import ptd_pkg::*; #(
	parameter int MIN_MS = 0 // Least width in ms; 0 only synchronises
) (
	input wire logic pclk, // Scan clock
	input wire logic presetn, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic ms_tick, // One pulse each ms
	input wire logic din, // Raw PLC input
	output logic dout // Qualified level
);
	// One extra tick guarantees the full time despite tick phase
	localparam logic [MS_CNT_W-1:0] THR = (MIN_MS == 0) ? '0 : MS_CNT_W'(MIN_MS + 1);
	logic s1_reg; // First sync stage, read only by second
	logic s2_reg; // Second sync stage
	logic [MS_CNT_W-1:0] cnt_reg; // Ms held so far

	// ==========================================================
	// Synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
		end else if (ce) begin
			s1_reg <= din;
			s2_reg <= s1_reg;
		end
	end

	// Width counter, saturating; short pulses never reach THR
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
			dout <= 1'b0;
		end else if (ce) begin
			if (!s2_reg) begin
				cnt_reg <= '0; // Drop clears
			end else if (ms_tick && cnt_reg < THR) begin
				cnt_reg <= cnt_reg + 1'b1;
			end
			dout <= s2_reg && (cnt_reg >= THR); // [RL22]
		end
	end
endmodule // ptd_qual

// *** logic/ptd_device.sv ***
// Device end: teach mode, jog/inch, position capture and direct moves
`timescale 1ns/100ps
// Summary of operation
// [RL1] Capture after request held 20 ms
// [RL2] Raise capture-done when store finished
// [RL3] Drop capture-done after request drops
// [RL4] Empty entry gets default band fields
// [RL5] Mode select enters teach, flags it
// [RL6] Teach entered only while actuator stationary
// [RL7] Both jogs stop; release both to resume
// [RL8] Inch select high steps, low jogs
// [RL9] Step distance and jog speed from parameters
// [RL10] Seven direct inputs for positions 0-6
// [RL11] Direct move on rising edge, 6 ms
// [RL12] Simultaneous commands: lowest number first
// [RL13] PLC asserts one direct input only
// [RL14] Parameter selects level or edge; 0 level
// [RL15] Level: input drop decelerates and finishes
// [RL16] Edge: runs to target regardless
// [RL17] PLC drops command after target reached
// [RL18] Hold low stops; high resumes
// [RL19] Hold disable parameter ignores hold input
// [RL20] Edge held: clear cancels remaining travel
// [RL21] Edge held: new command becomes target
// [RL22] Inputs synchronised and width-qualified in ms
module ptd_device import ptd_pkg::*; #(
	parameter int CYC_PER_MS = CYC_PER_MS_DEF // Shorten in simulation
) (
	input wire logic pclk, // Scan clock
	input wire logic presetn, // Async reset, active low
	input wire logic ce, // Clock enable
	ptd_if.dev pio, // PLC facing pins
	input wire logic actuator_moving, // Motion generator busy
	input wire logic at_target, // Target position reached
	input wire logic [POS_W-1:0] current_position, // Actuator position
	input wire logic entry_empty, // Selected entry has no position
	input wire logic [PAR_W-1:0] inch_step_dist, // Inching distance parameter
	input wire logic [PAR_W-1:0] jog_speed, // Jog speed parameter
	input wire logic edge_mode, // Command mode parameter, 0 level
	input wire logic hold_disable, // Hold disable parameter
	output logic drive_run, // Run toward drive_target; low decelerates
	output logic [IDX_W-1:0] drive_target, // Target position number
	output logic drive_cancel, // Pulse: drop remaining travel
	output logic jog_run, // Continuous jog
	output logic jog_reverse, // Jog or step direction
	output logic inch_step, // Pulse: one inching step
	output logic [PAR_W-1:0] step_distance, // Inching distance
	output logic [PAR_W-1:0] speed_out, // Jog speed
	output logic table_wr, // Pulse: write table entry
	output logic [IDX_W-1:0] table_wr_idx, // Entry written
	output logic [POS_W-1:0] table_wr_pos, // Position written
	output logic table_wr_defaults // Fill other fields with defaults
);
	// ==========================================================
	// Declarations
	logic [TICK_W-1:0] div_reg; // Ms divider
	logic tick_reg; // Ms pulse
	logic [N_IN-1:0] raw; // Raw pins gathered
	logic [N_IN-1:0] q; // Qualified pins
	logic [N_IN-1:0] q_d_reg; // Previous qualified pins
	logic [N_DIRECT-1:0] dm; // Direct commands, qualified
	logic [N_DIRECT-1:0] dm_rise; // Rising edges of commands
	logic [N_DIRECT-1:0] pend_reg; // Commands waiting
	logic [N_DIRECT-1:0] pend_next;
	logic [N_DIRECT-1:0] pend_cand; // Commands eligible to start
	ptd_state_t state_reg; // Direct-move state
	logic teach_reg; // Teach mode in effect
	logic lock_reg; // Jog locked after both pressed
	logic cap_busy_reg; // Capture written, awaiting release
	logic done_reg; // Capture done
	logic hold_act; // Hold in force
	logic jog_one; // Exactly one jog input

	// Lowest set bit index, used for start and retarget
	function automatic logic [IDX_W-1:0] lowest(input logic [N_DIRECT-1:0] v);
		logic [IDX_W-1:0] r;
		r = '0;
		for (int i = N_DIRECT - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = IDX_W'(i); // [RL12]
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Millisecond tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end else if (ce) begin
			tick_reg <= (div_reg == TICK_W'(CYC_PER_MS - 1));
			if (div_reg == TICK_W'(CYC_PER_MS - 1)) begin
				div_reg <= '0;
			end else begin
				div_reg <= div_reg + 1'b1;
			end
		end
	end

	// ==========================================================
	// Input conditioning, one qualifier per pin
	assign raw = {pio.direct_move_cmd_n, pio.clear_travel_input, pio.capture_position_request,
		pio.cmd_position, pio.hold_n, pio.inch_jog_select, pio.jog_rev, pio.jog_fwd, pio.mode_select};

	genvar gi;
	generate
		for (gi = 0; gi < N_IN; gi++) begin : g_in
			ptd_qual #(.MIN_MS(thr_ms(gi))) u_q (
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.ms_tick(tick_reg),
				.din(raw[gi]),
				.dout(q[gi])
			); // [RL22]
		end
	endgenerate

	// Edge history of qualified pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_d_reg <= '0;
		end else if (ce) begin
			q_d_reg <= q;
		end
	end

	assign dm = q[IN_DM0 +: N_DIRECT]; // [RL10]
	assign dm_rise = dm & ~q_d_reg[IN_DM0 +: N_DIRECT]; // [RL11]
	assign hold_act = !q[IN_HOLD] && !hold_disable; // [RL18] [RL19]
	assign jog_one = q[IN_JFWD] ^ q[IN_JREV];

	// ==========================================================
	// Teach mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			teach_reg <= 1'b0;
		end else if (ce) begin
			if (!q[IN_MODE]) begin
				teach_reg <= 1'b0;
			end else if (!q_d_reg[IN_MODE] && !actuator_moving && state_reg == ST_IDLE) begin
				teach_reg <= 1'b1; // [RL5] [RL6]
			end
		end
	end

	// ==========================================================
	// Jog and inch; lock holds until both inputs are released
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_reg <= 1'b0;
			jog_run <= 1'b0;
			jog_reverse <= 1'b0;
			inch_step <= 1'b0;
			step_distance <= '0;
			speed_out <= '0;
		end else if (ce) begin
			if (q[IN_JFWD] && q[IN_JREV]) begin
				lock_reg <= 1'b1; // [RL7]
			end else if (!q[IN_JFWD] && !q[IN_JREV]) begin
				lock_reg <= 1'b0; // [RL7]
			end
			// Both pressed stops at once, not one cycle late
			jog_run <= teach_reg && !q[IN_INCH] && jog_one && !lock_reg; // [RL8] [RL7]
			inch_step <= teach_reg && q[IN_INCH] && jog_one && !lock_reg
				&& !(q_d_reg[IN_JFWD] ^ q_d_reg[IN_JREV]); // [RL8]
			jog_reverse <= q[IN_JREV];
			step_distance <= inch_step_dist; // [RL9]
			speed_out <= jog_speed; // [RL9]
		end
	end

	// ==========================================================
	// Position capture, four-phase handshake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_busy_reg <= 1'b0;
			done_reg <= 1'b0;
			table_wr <= 1'b0;
			table_wr_idx <= '0;
			table_wr_pos <= '0;
			table_wr_defaults <= 1'b0;
		end else if (ce) begin
			table_wr <= 1'b0;
			if (!q[IN_CAP]) begin
				cap_busy_reg <= 1'b0;
				done_reg <= 1'b0; // [RL3]
			end else if (teach_reg && !cap_busy_reg) begin
				cap_busy_reg <= 1'b1; // [RL1]
				table_wr <= 1'b1;
				table_wr_idx <= q[IN_POS0 +: IDX_W];
				table_wr_pos <= current_position;
				table_wr_defaults <= entry_empty; // [RL4]
			end else if (table_wr) begin
				done_reg <= 1'b1; // [RL2]
			end
		end
	end

	// ==========================================================
	// Pending commands; level mode forgets a command once dropped
	assign pend_cand = edge_mode ? pend_reg | dm_rise : (pend_reg | dm_rise) & dm; // [RL14] [RL15]
	// The command started or retargeted to is taken off, so it never runs twice
	always_comb begin
		pend_next = pend_cand;
		if (state_reg == ST_HOLD && edge_mode && q[IN_CLR]) begin
			pend_next = '0; // [RL20]
		end else if (pend_cand != '0 && (state_reg == ST_IDLE ? !teach_reg
			: (state_reg == ST_HOLD && edge_mode && !hold_act))) begin
			pend_next[lowest(pend_cand)] = 1'b0; // [RL21]
		end
	end

	// Direct move sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			pend_reg <= '0;
			drive_run <= 1'b0;
			drive_target <= '0;
			drive_cancel <= 1'b0;
		end else if (ce) begin
			pend_reg <= pend_next;
			drive_cancel <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					// Lowest waiting number wins
					if (!teach_reg && pend_cand != '0) begin
						drive_target <= lowest(pend_cand); // [RL12]
						drive_run <= 1'b1; // [RL10]
						state_reg <= ST_MOVE;
					end
				end
				ST_MOVE: begin
					if (hold_act) begin
						drive_run <= 1'b0; // [RL18]
						state_reg <= ST_HOLD;
					end else if (at_target) begin
						drive_run <= 1'b0; // [RL16]
						state_reg <= ST_IDLE;
					end else if (!edge_mode && !dm[drive_target]) begin
						drive_run <= 1'b0; // [RL15]
						state_reg <= ST_STOP;
					end
				end
				ST_HOLD: begin
					if (edge_mode && q[IN_CLR]) begin
						drive_cancel <= 1'b1; // [RL20]
						state_reg <= ST_STOP;
					end else if (!hold_act) begin
						if (edge_mode && pend_cand != '0) begin
							drive_target <= lowest(pend_cand); // [RL21]
						end
						drive_run <= 1'b1; // [RL18]
						state_reg <= ST_MOVE;
					end
				end
				ST_STOP: begin
					// Wait for deceleration to finish
					if (!actuator_moving) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Status pins, all from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pio.capture_done <= 1'b0;
			pio.teach_mode_active <= 1'b0;
			pio.move_active <= 1'b0;
		end else if (ce) begin
			pio.capture_done <= done_reg; // [RL2]
			pio.teach_mode_active <= teach_reg; // [RL5]
			pio.move_active <= (state_reg != ST_IDLE);
		end
	end
endmodule // ptd_device

// *** logic/ptd_plc.sv ***
// PLC end: APB register slave that drives the parallel command pins
`timescale 1ns/100ps
module ptd_plc import ptd_pkg::*; (
	input wire logic pclk, // APB clock
	input wire logic presetn, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	ptd_if.plc pio // Pins toward the device
);
	logic [31:0] ctrl_reg; // Control bits
	logic [N_DIRECT-1:0] move_reg; // Direct move bits
	logic setup; // Setup phase of a transfer
	logic bad; // Unmapped or illegal write

	// More than one direct bit is illegal
	function automatic logic multi(input logic [N_DIRECT-1:0] v);
		return (v & (v - 1'b1)) != '0;
	endfunction

	assign setup = psel && !penable;
	// A write with several direct bits is refused outright
	assign bad = !(paddr == ADDR_CTRL || paddr == ADDR_MOVE || paddr == ADDR_STAT)
		|| (pwrite && paddr == ADDR_STAT)
		|| (pwrite && paddr == ADDR_MOVE && multi(pwdata[N_DIRECT-1:0])); // [RL13]

	// ==========================================================
	// Answer prepared in setup, valid during access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= setup;
			pslverr <= setup && bad;
			if (setup && !pwrite && paddr == ADDR_CTRL) begin
				prdata <= ctrl_reg;
			end else if (setup && !pwrite && paddr == ADDR_MOVE) begin
				prdata <= 32'(move_reg);
			end else if (setup && !pwrite && paddr == ADDR_STAT) begin
				prdata <= 32'({pio.move_active, pio.teach_mode_active, pio.capture_done});
			end else begin
				prdata <= '0;
			end
		end
	end

	// Writes take effect at the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RST;
			move_reg <= '0;
		end else if (ce && psel && penable && pready && pwrite && !pslverr) begin
			if (paddr == ADDR_CTRL) begin
				ctrl_reg <= pwdata;
			end else if (paddr == ADDR_MOVE) begin
				move_reg <= pwdata[N_DIRECT-1:0];
			end
		end
	end

	// ==========================================================
	// Pin drivers, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pio.mode_select <= 1'b0;
			pio.jog_fwd <= 1'b0;
			pio.jog_rev <= 1'b0;
			pio.inch_jog_select <= 1'b0;
			pio.hold_n <= 1'b1;
			pio.cmd_position <= '0;
			pio.capture_position_request <= 1'b0;
			pio.clear_travel_input <= 1'b0;
			pio.direct_move_cmd_n <= '0;
		end else if (ce) begin
			pio.mode_select <= ctrl_reg[IN_MODE];
			pio.jog_fwd <= ctrl_reg[IN_JFWD];
			pio.jog_rev <= ctrl_reg[IN_JREV];
			pio.inch_jog_select <= ctrl_reg[IN_INCH];
			pio.hold_n <= ctrl_reg[IN_HOLD];
			pio.cmd_position <= ctrl_reg[CB_POS +: IDX_W];
			pio.capture_position_request <= ctrl_reg[IN_CAP]; // [RL1]
			pio.clear_travel_input <= ctrl_reg[IN_CLR]; // [RL20]
			pio.direct_move_cmd_n <= move_reg; // [RL11]
		end
	end
endmodule // ptd_plc

// *** verif/ptd_monitor.sv ***
// Interface checker for the PIO teach and direct-move link
`timescale 1ns/100ps
module ptd_monitor import ptd_pkg::*; #(
	parameter int CYC_PER_MS = CYC_PER_MS_DEF // Scan cycles per ms
) (
	input wire logic pclk, // Scan clock
	input wire logic presetn, // Async reset, active low
	input wire logic mode_select, // Teach request pin
	input wire logic capture_position_request, // Capture request pin
	input wire logic [N_DIRECT-1:0] direct_move_cmd_n, // Direct move pins
	input wire logic capture_done, // Capture finished
	input wire logic teach_mode_active, // Teach in effect
	input wire logic move_active // Move in progress
);
	// ==========================================================
	// Run-length counters
	int cap_cnt; // Cycles the capture request has stood high
	int dm_cnt; // Cycles any direct pin has stood high
	// Saturate so that a long hold never wraps to a small count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_cnt <= 0;
			dm_cnt <= 0;
		end else begin
			cap_cnt <= capture_position_request ? cap_cnt + (cap_cnt < 99999) : 0;
			dm_cnt <= (|direct_move_cmd_n) ? dm_cnt + (dm_cnt < 99999) : 0;
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_done_up;
		$rose(capture_done);
	endsequence
	sequence s_req_drop;
		$fell(capture_position_request);
	endsequence
	chk_cap_min_hold: assert property (s_done_up |-> cap_cnt >= CAP_MIN_MS * CYC_PER_MS)
		else $error("capture done too early");
	chk_cap_done_due: assert property ((teach_mode_active && cap_cnt == 21 * CYC_PER_MS + 20) |-> ##[0:60] capture_done)
		else $error("capture done missing");
	chk_done_drops: assert property (s_req_drop |-> ##[1:10] !capture_done)
		else $error("capture done stuck");
	chk_done_stays: assert property (capture_done && capture_position_request |=> capture_done)
		else $error("capture done fell while request held");
	chk_teach_cause: assert property ($rose(teach_mode_active) |-> mode_select && $past(mode_select, 2))
		else $error("teach without mode select");
	chk_teach_exit: assert property ($fell(mode_select) |-> ##[1:10] !teach_mode_active)
		else $error("teach mode stuck");
	chk_teach_idle: assert property ($rose(teach_mode_active) |-> !move_active)
		else $error("teach during a move");
	chk_move_qual: assert property ($rose(move_active) |-> dm_cnt >= CMD_MIN_MS * CYC_PER_MS)
		else $error("move on short command");
	chk_move_no_teach: assert property ($rose(move_active) |-> !teach_mode_active)
		else $error("move in teach mode");
endmodule // ptd_monitor

// *** verif/pio_teach_and_direct_move_tb.sv ***
// Self-checking bench joining the PLC end and the device end
`timescale 1ns/100ps
module pio_teach_and_direct_move_tb;
	import ptd_pkg::*;
	// ==========================================================
	// Signals
	localparam int CPM = 50; // Short ms keeps the run brief
	localparam logic [31:0] B = CTRL_RST | 32'h0000_0001; // Teach on, hold released
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0; // Clock, reset, APB
	logic [11:0] paddr = '0; // APB address
	logic [31:0] pwdata = '0, prdata, rd; // APB data and last read
	logic pready, pslverr, er; // APB answer and last error
	logic actuator_moving = 0, at_target = 0, entry_empty = 0, edge_mode = 0, hold_disable = 0, mv_force = 0;
	logic [POS_W-1:0] current_position = '0, exp_pos; // Position fed and expected
	logic [PAR_W-1:0] inch_step_dist = '0, jog_speed = '0; // Parameter values
	logic drive_run, drive_cancel, jog_run, jog_reverse, inch_step, table_wr, table_wr_defaults;
	logic [IDX_W-1:0] drive_target, table_wr_idx, p; // Targets and entry numbers
	logic [POS_W-1:0] table_wr_pos; // Written position
	logic [PAR_W-1:0] step_distance, speed_out; // Parameter pass-through
	logic [35:0] wr_q[$], w; // Table writes seen, oldest first
	int fails = 0, n_compared = 0, seed = 32'h24ba, n_inch = 0, n_cancel = 0;
	// ==========================================================
	// Design
	ptd_if pio();
	ptd_plc i_ptd_plc(.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.pio);
	ptd_device #(.CYC_PER_MS(CPM)) i_ptd_device(.pclk, .presetn, .ce, .pio, .actuator_moving, .at_target,
		.current_position, .entry_empty, .inch_step_dist, .jog_speed, .edge_mode, .hold_disable, .drive_run,
		.drive_target, .drive_cancel, .jog_run, .jog_reverse, .inch_step, .step_distance, .speed_out, .table_wr,
		.table_wr_idx, .table_wr_pos, .table_wr_defaults);
	ptd_monitor #(.CYC_PER_MS(CPM)) u_mon(.pclk, .presetn, .mode_select(pio.mode_select),
		.capture_position_request(pio.capture_position_request), .direct_move_cmd_n(pio.direct_move_cmd_n),
		.capture_done(pio.capture_done), .teach_mode_active(pio.teach_mode_active), .move_active(pio.move_active));
	// ==========================================================
	// Clock and actuator model
	initial begin
		forever #10 pclk = ~pclk;
	end
	// Actuator lags run by a cycle; writes and pulses logged
	always @(posedge pclk) begin
		actuator_moving <= drive_run | mv_force;
		if (table_wr === 1'b1) begin
			wr_q.push_back({table_wr_idx, table_wr_pos, table_wr_defaults});
		end
		n_inch += (inch_step === 1'b1);
		n_cancel += (drive_cancel === 1'b1);
	end
	// ==========================================================
	// Tasks
	task automatic final_report;
		if (fails == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer; holds the request until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) begin
			fails++;
			final_report();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	function automatic bit cond(input int k);
		case (k)
			0: return pio.capture_done === 1'b1;
			1: return pio.capture_done === 1'b0;
			2: return pio.move_active === 1'b1;
			3: return pio.move_active === 1'b0;
			4: return pio.teach_mode_active === 1'b1;
			5: return drive_run === 1'b0;
			default: return drive_run === 1'b1;
		endcase
	endfunction
	// Bounded wait; running out counts as a mismatch
	task automatic wt(input int k);
		int n = 0;
		while (!cond(k) && n < 5000) begin
			@(posedge pclk);
			n++;
		end
		if (!cond(k)) begin
			fails++;
			final_report();
		end
	endtask
	task automatic reach;
		at_target <= 1;
		@(posedge pclk);
		at_target <= 0;
		wt(3);
	endtask
	// ==========================================================
	// Scenarios
	initial begin
		cyc(3);
		presetn <= 1;
		@(posedge pclk);
		apb(0, ADDR_CTRL, 0);
		chk(rd, CTRL_RST);
		apb(0, ADDR_STAT, 0);
		chk(rd, 0);
		apb(0, 12'hff0, 0);
		chk(er, 1);
		apb(1, ADDR_STAT, 1);
		chk(er, 1);
		apb(1, ADDR_MOVE, 32'h0000_0003);
		chk(er, 1);
		// Teach refused while moving, taken when still
		mv_force <= 1;
		apb(1, ADDR_CTRL, B);
		cyc(20);
		chk(pio.teach_mode_active, 0);
		apb(1, ADDR_CTRL, CTRL_RST);
		mv_force <= 0;
		cyc(10);
		apb(1, ADDR_CTRL, B);
		wt(4);
		apb(0, ADDR_STAT, 0);
		chk(rd[SB_TEACH], 1);
		// Short capture request must be ignored
		apb(1, ADDR_CTRL, B | 32'h0000_0100);
		cyc(10 * CPM);
		apb(1, ADDR_CTRL, B);
		cyc(50);
		chk(wr_q.size(), 0);
		for (int i = 0; i < 2; i++) begin
			exp_pos = $random(seed);
			p = $random(seed);
			current_position <= exp_pos;
			entry_empty <= i;
			apb(1, ADDR_CTRL, B | 32'h0000_0100 | (p << CB_POS));
			wt(0);
			cyc(20);
			apb(0, ADDR_STAT, 0);
			chk(rd[SB_DONE], 1);
			chk(wr_q.size(), 1);
			w = wr_q.pop_front();
			chk(w[35:33], p);
			chk(w[32:1], exp_pos);
			chk(w[0], i);
			apb(1, ADDR_CTRL, B | (p << CB_POS));
			wt(1);
		end
		// Jogging, both-jog lockout and inching
		jog_speed <= $random(seed);
		inch_step_dist <= $random(seed);
		apb(1, ADDR_CTRL, B | 2);
		cyc(10);
		chk(jog_run, 1);
		chk(jog_reverse, 0);
		chk(speed_out, jog_speed);
		apb(1, ADDR_CTRL, B | 6);
		cyc(10);
		chk(jog_run, 0);
		apb(1, ADDR_CTRL, B | 4);
		cyc(10);
		chk(jog_run, 0);
		apb(1, ADDR_CTRL, B);
		cyc(10);
		apb(1, ADDR_CTRL, B | 4);
		cyc(10);
		chk(jog_run, 1);
		chk(jog_reverse, 1);
		apb(1, ADDR_CTRL, B | 8);
		cyc(10);
		n_inch = 0;
		apb(1, ADDR_CTRL, B | 8 | 4);
		cyc(10);
		chk(n_inch, 1);
		chk(jog_run, 0);
		chk(step_distance, inch_step_dist);
		apb(1, ADDR_CTRL, CTRL_RST);
		cyc(10);
		chk(pio.teach_mode_active, 0);
		// Each direct input, level then edge
		for (int m = 0; m < 2; m++) begin
			edge_mode <= m;
			for (int i = 0; i < N_DIRECT; i++) begin
				apb(1, ADDR_MOVE, 1 << i);
				wt(2);
				chk(drive_target, i);
				chk(drive_run, 1);
				apb(1, ADDR_MOVE, 0);
				cyc(10);
				chk(drive_run, m);
				if (m) begin
					reach();
				end
				wt(3);
			end
		end
		// Too short a command never starts a move
		apb(1, ADDR_MOVE, 1);
		cyc(3 * CPM);
		apb(1, ADDR_MOVE, 0);
		cyc(CPM);
		chk(pio.move_active, 0);
		// Edge mode hold, retarget on release
		apb(1, ADDR_MOVE, 2);
		wt(2);
		apb(1, ADDR_CTRL, 0);
		wt(5);
		chk(pio.move_active, 1);
		apb(1, ADDR_MOVE, 8);
		cyc(8 * CPM);
		apb(1, ADDR_CTRL, CTRL_RST);
		wt(6);
		chk(drive_target, 3);
		reach();
		apb(1, ADDR_MOVE, 0);
		// Held move cancelled by clear pulse
		apb(1, ADDR_MOVE, 1);
		wt(2);
		apb(1, ADDR_MOVE, 0);
		apb(1, ADDR_CTRL, 0);
		wt(5);
		n_cancel = 0;
		apb(1, ADDR_CTRL, 32'h0000_0200);
		cyc(8 * CPM);
		apb(1, ADDR_CTRL, 0);
		chk(n_cancel, 1);
		wt(3);
		apb(1, ADDR_CTRL, CTRL_RST);
		cyc(20);
		chk(drive_run, 0);
		// Hold ignored when disabled
		hold_disable <= 1;
		apb(1, ADDR_MOVE, 4);
		wt(2);
		apb(1, ADDR_CTRL, 0);
		cyc(20);
		chk(drive_run, 1);
		apb(1, ADDR_CTRL, CTRL_RST);
		cyc(5);
		hold_disable <= 0;
		reach();
		apb(1, ADDR_MOVE, 0);
		// Mid-run reset restores defaults
		apb(1, ADDR_CTRL, B);
		presetn <= 0;
		cyc(2);
		presetn <= 1;
		@(posedge pclk);
		apb(0, ADDR_CTRL, 0);
		chk(rd, CTRL_RST);
		final_report();
	end
endmodule // pio_teach_and_direct_move_tb
